// file: src/hrs_pkg.sv
// constants, field layout and state codes of the home return sequencer
package hrs_pkg;

	// ****************************************************************
	// widths
	// ****************************************************************
	localparam int unsigned ADDR_W = 4;
	localparam int unsigned DATA_W = 32;
	localparam int unsigned SPD_W  = 16;
	localparam int unsigned POS_W  = 32;
	localparam int unsigned PRE_W  = 7;

	// ****************************************************************
	// register offsets (word index on the plain port)
	// ****************************************************************
	localparam logic [ADDR_W-1:0] REG_TYPE        = 4'h0;
	localparam logic [ADDR_W-1:0] REG_DOG_POL     = 4'h1;
	localparam logic [ADDR_W-1:0] REG_HOME_SPEED  = 4'h2;
	localparam logic [ADDR_W-1:0] REG_CREEP_SPEED = 4'h3;
	localparam logic [ADDR_W-1:0] REG_SHIFT       = 4'h4;
	localparam logic [ADDR_W-1:0] REG_HOME_POS    = 4'h5;
	localparam logic [ADDR_W-1:0] REG_TRAVEL      = 4'h6;
	localparam logic [ADDR_W-1:0] REG_ACCEL       = 4'h7;
	localparam logic [ADDR_W-1:0] REG_DECEL       = 4'h8;
	localparam logic [ADDR_W-1:0] REG_PROG        = 4'h9;
	localparam logic [ADDR_W-1:0] REG_STATUS      = 4'ha;
	localparam logic [ADDR_W-1:0] REG_POSITION    = 4'hb;

	// ****************************************************************
	// fields
	// ****************************************************************
	localparam int unsigned TYPE_DIR_BIT  = 4;
	localparam int unsigned STAT_BUSY_BIT = 0;
	localparam int unsigned STAT_DONE_BIT = 1;
	localparam int unsigned STAT_WARN_BIT = 2;

	localparam logic [3:0] METHOD_LAST_Z  = 4'h8;
	localparam logic [3:0] METHOD_FRONT   = 4'h9;
	localparam logic [3:0] METHOD_DOGLESS = 4'ha;

	// ****************************************************************
	// reset values
	// ****************************************************************
	localparam logic [4:0]       RST_TYPE        = 5'h08;
	localparam logic             RST_DOG_POL     = 1'b1;
	localparam logic [SPD_W-1:0] RST_HOME_SPEED  = 16'h0064;
	localparam logic [SPD_W-1:0] RST_CREEP_SPEED = 16'h000a;
	localparam logic [POS_W-1:0] RST_DIST        = 32'h0000_0000;
	localparam logic [SPD_W-1:0] RST_RAMP        = 16'h0000;
	localparam logic [3:0]       RST_PROG        = 4'h0;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int unsigned CLK_NS        = 10;
	localparam int unsigned RAMP_TICK_NS  = 1000;
	localparam int unsigned RAMP_TICK_CYC = (RAMP_TICK_NS + CLK_NS - 1) / CLK_NS;

	// ****************************************************************
	// sequencer states
	// ****************************************************************
	typedef enum logic [8:0] {
		ST_IDLE    = 9'h001,
		ST_OFFDOG  = 9'h002,
		ST_PAUSE   = 9'h004,
		ST_FAST    = 9'h008,
		ST_REVSEEK = 9'h010,
		ST_ZSEEK   = 9'h020,
		ST_SHIFT   = 9'h040,
		ST_FINISH  = 9'h080,
		ST_FAULT   = 9'h100
	} hrs_state_t;

endpackage

// file: src/hrs_ramp_if.sv
// speed ramp request and answer between sequencer and ramp generator
`timescale 1ns/1ps
interface hrs_ramp_if;
	logic [hrs_pkg::SPD_W-1:0] target;
	logic [hrs_pkg::SPD_W-1:0] accel_period;
	logic [hrs_pkg::SPD_W-1:0] decel_period;
	logic [hrs_pkg::SPD_W-1:0] speed;

	modport ctl (output target, output accel_period, output decel_period, input speed);
	modport ramp (input target, input accel_period, input decel_period, output speed);
endinterface

// file: src/hrs_ramp.sv
// speed ramp generator: one speed unit per period plus one ramp ticks
`timescale 1ns/1ps
module hrs_ramp (
	input wire logic clk,
	input wire logic rst_sync_b,
	hrs_ramp_if.ramp rif
);

	// ****************************************************************
	// tick prescaler and step decision
	// ****************************************************************
	localparam logic [hrs_pkg::PRE_W-1:0] PRE_LAST = hrs_pkg::PRE_W'(hrs_pkg::RAMP_TICK_CYC - 1);

	logic [hrs_pkg::PRE_W-1:0] pre;
	logic [hrs_pkg::SPD_W-1:0] cnt;

	wire                      tick   = (pre == PRE_LAST);
	wire                      up     = (rif.target > rif.speed);
	wire                      down   = (rif.target < rif.speed);
	wire [hrs_pkg::SPD_W-1:0] period = up ? rif.accel_period : rif.decel_period;
	wire                      step   = tick & (cnt >= period);

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pre <= '0;
		end else begin
			pre <= tick ? '0 : pre + 7'h01;
		end
	end

	// ****************************************************************
	// speed integrator
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			cnt       <= '0;
			rif.speed <= '0;
		end else if (!(up | down)) begin
			cnt <= '0;
		end else if (step) begin
			cnt       <= '0;
			rif.speed <= up ? rif.speed + 16'h0001 : rif.speed - 16'h0001;
		end else if (tick) begin
			cnt <= cnt + 16'h0001;
		end
	end

endmodule

// file: src/hrs_top.sv
// home position return sequencer with settings port and motion profile output
//
// Notes on behaviour
// - last z mode: after dog front, reverse at creep; first z plus shift distance is home
// - method code 8 selects last z reference with dog
// - method code 9 selects front end reference with dog
// - front end mode: home is dog front plus travel plus shift
// - front end mode ignores z; home moves with creep speed
// - front end error follows dog sampling, about 200 pulses at 100 r/min
// - method code a selects dogless z reference
// - dogless mode: first z after start plus shift distance is home
// - home return speed until dog, then creep speed
// - ramps use dedicated home return accel and decel times
// - on completion current position is loaded with home position data
// - dog active level follows dog polarity setting
// - start on dog: back off first, then normal return
// - start beyond dog: reverse at stroke end, pass dog, stop, restart
// - dog never found: stop at opposite stroke end and warn
// - only hardware stroke end inputs reverse the retract
`timescale 1ns/1ps
module hrs_top (
	input  wire logic                         clk,
	input  wire logic                         rst_b,
	input  wire logic [hrs_pkg::ADDR_W-1:0]   reg_addr,
	input  wire logic [hrs_pkg::DATA_W-1:0]   reg_wdata,
	input  wire logic                         reg_wr,
	input  wire logic                         reg_rd,
	output logic      [hrs_pkg::DATA_W-1:0]   reg_rdata,
	input  wire logic                         op_mode_select_1,
	input  wire logic [3:0]                   program_select,
	input  wire logic                         zero_return_command,
	input  wire logic                         dog_input,
	input  wire logic                         forward_stroke_end_input,
	input  wire logic                         reverse_stroke_end_input,
	input  wire logic                         z_phase,
	input  wire logic                         enc_step,
	input  wire logic                         enc_dir,
	output logic      [hrs_pkg::SPD_W-1:0]    motion_speed,
	output logic                              motion_dir,
	output logic                              return_busy,
	output logic                              home_complete_output,
	output logic                              home_incomplete_warning
);

	// ****************************************************************
	// reset release
	// ****************************************************************
	logic rst_meta_b;
	logic rst_sync_b;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_meta_b <= 1'b1;
			rst_sync_b <= rst_meta_b;
		end
	end

	// ****************************************************************
	// settings registers
	// ****************************************************************
	logic [4:0]                home_return_type_setting;
	logic                      dog_polarity_setting;
	logic [hrs_pkg::SPD_W-1:0] home_return_speed_setting;
	logic [hrs_pkg::SPD_W-1:0] creep_speed_setting;
	logic [hrs_pkg::POS_W-1:0] home_shift_distance_setting;
	logic [hrs_pkg::POS_W-1:0] home_position_data_setting;
	logic [hrs_pkg::POS_W-1:0] travel_after_dog_setting;
	logic [hrs_pkg::SPD_W-1:0] home_accel_time_setting;
	logic [hrs_pkg::SPD_W-1:0] home_decel_time_setting;
	logic [3:0]                zero_return_program;

	wire wr_type   = reg_wr & (reg_addr == hrs_pkg::REG_TYPE);
	wire wr_pol    = reg_wr & (reg_addr == hrs_pkg::REG_DOG_POL);
	wire wr_hspd   = reg_wr & (reg_addr == hrs_pkg::REG_HOME_SPEED);
	wire wr_cspd   = reg_wr & (reg_addr == hrs_pkg::REG_CREEP_SPEED);
	wire wr_shift  = reg_wr & (reg_addr == hrs_pkg::REG_SHIFT);
	wire wr_hpos   = reg_wr & (reg_addr == hrs_pkg::REG_HOME_POS);
	wire wr_travel = reg_wr & (reg_addr == hrs_pkg::REG_TRAVEL);
	wire wr_accel  = reg_wr & (reg_addr == hrs_pkg::REG_ACCEL);
	wire wr_decel  = reg_wr & (reg_addr == hrs_pkg::REG_DECEL);
	wire wr_prog   = reg_wr & (reg_addr == hrs_pkg::REG_PROG);

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			home_return_type_setting    <= hrs_pkg::RST_TYPE;
			dog_polarity_setting        <= hrs_pkg::RST_DOG_POL;
			home_return_speed_setting   <= hrs_pkg::RST_HOME_SPEED;
			creep_speed_setting         <= hrs_pkg::RST_CREEP_SPEED;
			home_shift_distance_setting <= hrs_pkg::RST_DIST;
			home_position_data_setting  <= hrs_pkg::RST_DIST;
			travel_after_dog_setting    <= hrs_pkg::RST_DIST;
			home_accel_time_setting     <= hrs_pkg::RST_RAMP;
			home_decel_time_setting     <= hrs_pkg::RST_RAMP;
			zero_return_program         <= hrs_pkg::RST_PROG;
		end else begin
			if (wr_type)   home_return_type_setting    <= reg_wdata[4:0];
			if (wr_pol)    dog_polarity_setting        <= reg_wdata[0];
			if (wr_hspd)   home_return_speed_setting   <= reg_wdata[15:0];
			if (wr_cspd)   creep_speed_setting         <= reg_wdata[15:0];
			if (wr_shift)  home_shift_distance_setting <= reg_wdata;
			if (wr_hpos)   home_position_data_setting  <= reg_wdata;
			if (wr_travel) travel_after_dog_setting    <= reg_wdata;
			if (wr_accel)  home_accel_time_setting     <= reg_wdata[15:0];
			if (wr_decel)  home_decel_time_setting     <= reg_wdata[15:0];
			if (wr_prog)   zero_return_program         <= reg_wdata[3:0];
		end
	end

	// ****************************************************************
	// input decoding
	// ****************************************************************
	hrs_pkg::hrs_state_t       state;
	hrs_pkg::hrs_state_t       next_state;
	logic                      want_dir;
	logic                      next_want_dir;
	logic [hrs_pkg::SPD_W-1:0] want_speed;
	logic [hrs_pkg::SPD_W-1:0] next_want_speed;
	logic [hrs_pkg::POS_W-1:0] remaining;
	logic [hrs_pkg::POS_W-1:0] next_remaining;
	logic                      seen_dog;
	logic                      next_seen_dog;
	logic                      next_done;
	logic                      next_warn;
	logic                      load_pos;
	logic                      z_q;
	logic [hrs_pkg::POS_W-1:0] position;

	hrs_ramp_if rif();

	wire [3:0] method    = home_return_type_setting[3:0];
	wire       ret_dir   = home_return_type_setting[hrs_pkg::TYPE_DIR_BIT];
	wire       m_last_z  = (method == hrs_pkg::METHOD_LAST_Z);
	wire       m_front   = (method == hrs_pkg::METHOD_FRONT);
	wire       m_dogless = (method == hrs_pkg::METHOD_DOGLESS);
	wire       uses_dog  = m_last_z | m_front;
	wire       method_ok = uses_dog | m_dogless;
	wire       dog_act   = dog_polarity_setting ? dog_input : ~dog_input;
	wire       z_rise    = z_phase & ~z_q;
	wire       at_zero   = (rif.speed == '0);
	wire       moving    = ~at_zero & (motion_dir == want_dir);
	// stroke end in the present travel direction; software limits play no part
	wire       stroke_ahead = moving & (motion_dir ? reverse_stroke_end_input
	                                               : forward_stroke_end_input);
	wire       prog_ok   = op_mode_select_1 & (program_select == zero_return_program);
	wire       start     = zero_return_command & prog_ok & method_ok;

	// ****************************************************************
	// sequencer
	// ****************************************************************
	always_comb begin
		next_state      = state;
		next_want_dir   = want_dir;
		next_want_speed = want_speed;
		next_remaining  = remaining;
		next_seen_dog   = seen_dog;
		next_done       = home_complete_output;
		next_warn       = home_incomplete_warning;
		load_pos        = 1'b0;
		case (state)
			hrs_pkg::ST_IDLE: begin
				if (start) begin
					next_done     = 1'b0;
					next_warn     = 1'b0;
					next_seen_dog = 1'b0;
					if (uses_dog & dog_act) begin
						next_state      = hrs_pkg::ST_OFFDOG;
						next_want_dir   = ~ret_dir;
						next_want_speed = creep_speed_setting;
					end else begin
						next_state      = hrs_pkg::ST_FAST;
						next_want_dir   = ret_dir;
						next_want_speed = home_return_speed_setting;
					end
				end
			end
			hrs_pkg::ST_OFFDOG: begin
				if (!dog_act) begin
					next_state      = hrs_pkg::ST_PAUSE;
					next_want_speed = '0;
				end else if (stroke_ahead) begin
					next_state      = hrs_pkg::ST_FAULT;
					next_want_speed = '0;
				end
			end
			hrs_pkg::ST_PAUSE: begin
				if (at_zero) begin
					next_state      = hrs_pkg::ST_FAST;
					next_want_dir   = ret_dir;
					next_want_speed = home_return_speed_setting;
				end
			end
			hrs_pkg::ST_FAST: begin
				if (uses_dog & dog_act & m_front) begin
					// front end reached: z is ignored, distance counted from here
					next_state      = hrs_pkg::ST_SHIFT;
					next_want_speed = creep_speed_setting;
					next_remaining  = travel_after_dog_setting + home_shift_distance_setting;
				end else if (uses_dog & dog_act) begin
					next_state      = hrs_pkg::ST_ZSEEK;
					next_want_dir   = ~ret_dir;
					next_want_speed = creep_speed_setting;
				end else if (m_dogless & z_rise & moving) begin
					next_state      = hrs_pkg::ST_SHIFT;
					next_want_speed = creep_speed_setting;
					next_remaining  = home_shift_distance_setting;
				end else if (stroke_ahead & uses_dog) begin
					next_state      = hrs_pkg::ST_REVSEEK;
					next_want_dir   = ~ret_dir;
				end else if (stroke_ahead) begin
					next_state      = hrs_pkg::ST_FAULT;
					next_want_speed = '0;
				end
			end
			hrs_pkg::ST_REVSEEK: begin
				if (dog_act) begin
					next_seen_dog = 1'b1;
				end
				if (seen_dog & ~dog_act) begin
					next_state      = hrs_pkg::ST_PAUSE;
					next_want_speed = '0;
				end else if (stroke_ahead & ~seen_dog & ~dog_act) begin
					next_state      = hrs_pkg::ST_FAULT;
					next_want_speed = '0;
				end
			end
			hrs_pkg::ST_ZSEEK: begin
				if (z_rise & moving) begin
					next_state     = hrs_pkg::ST_SHIFT;
					next_remaining = home_shift_distance_setting;
				end
			end
			hrs_pkg::ST_SHIFT: begin
				if (remaining == '0) begin
					next_state      = hrs_pkg::ST_FINISH;
					next_want_speed = '0;
					load_pos        = 1'b1;
				end else if (enc_step) begin
					next_remaining = remaining - 32'h0000_0001;
				end
			end
			hrs_pkg::ST_FINISH: begin
				if (at_zero) begin
					next_state = hrs_pkg::ST_IDLE;
					next_done  = 1'b1;
				end
			end
			hrs_pkg::ST_FAULT: begin
				if (at_zero) begin
					next_state = hrs_pkg::ST_IDLE;
					next_warn  = 1'b1;
				end
			end
			default: begin
				next_state      = hrs_pkg::ST_IDLE;
				next_want_speed = '0;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			state                   <= hrs_pkg::ST_IDLE;
			want_dir                <= 1'b0;
			want_speed              <= '0;
			remaining               <= '0;
			seen_dog                <= 1'b0;
			home_complete_output    <= 1'b0;
			home_incomplete_warning <= 1'b0;
			z_q                     <= 1'b0;
		end else begin
			state                   <= next_state;
			want_dir                <= next_want_dir;
			want_speed              <= next_want_speed;
			remaining               <= next_remaining;
			seen_dog                <= next_seen_dog;
			home_complete_output    <= next_done;
			home_incomplete_warning <= next_warn;
			z_q                     <= z_phase;
		end
	end

	// ****************************************************************
	// motion profile
	// ****************************************************************
	// a direction change first ramps down to standstill
	assign rif.target       = (motion_dir != want_dir) ? '0 : want_speed;
	assign rif.accel_period = home_accel_time_setting;
	assign rif.decel_period = home_decel_time_setting;

	hrs_ramp u_ramp (
		.clk        (clk),
		.rst_sync_b (rst_sync_b),
		.rif        (rif)
	);

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			motion_dir   <= 1'b0;
			motion_speed <= '0;
			return_busy  <= 1'b0;
		end else begin
			if (at_zero) motion_dir <= want_dir;
			motion_speed <= rif.speed;
			return_busy  <= (next_state != hrs_pkg::ST_IDLE);
		end
	end

	// ****************************************************************
	// current position
	// ****************************************************************
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			position <= '0;
		end else if (load_pos) begin
			position <= home_position_data_setting;
		end else if (enc_step) begin
			position <= enc_dir ? position - 32'h0000_0001 : position + 32'h0000_0001;
		end
	end

	// ****************************************************************
	// read port
	// ****************************************************************
	logic [hrs_pkg::DATA_W-1:0] rd_mux;
	wire  [hrs_pkg::DATA_W-1:0] status_word = {29'h0000_0000,
	                                           home_incomplete_warning,
	                                           home_complete_output,
	                                           return_busy};

	always_comb begin
		rd_mux = '0;
		case (reg_addr)
			hrs_pkg::REG_TYPE:        rd_mux = {27'h000_0000, home_return_type_setting};
			hrs_pkg::REG_DOG_POL:     rd_mux = {31'h0000_0000, dog_polarity_setting};
			hrs_pkg::REG_HOME_SPEED:  rd_mux = {16'h0000, home_return_speed_setting};
			hrs_pkg::REG_CREEP_SPEED: rd_mux = {16'h0000, creep_speed_setting};
			hrs_pkg::REG_SHIFT:       rd_mux = home_shift_distance_setting;
			hrs_pkg::REG_HOME_POS:    rd_mux = home_position_data_setting;
			hrs_pkg::REG_TRAVEL:      rd_mux = travel_after_dog_setting;
			hrs_pkg::REG_ACCEL:       rd_mux = {16'h0000, home_accel_time_setting};
			hrs_pkg::REG_DECEL:       rd_mux = {16'h0000, home_decel_time_setting};
			hrs_pkg::REG_PROG:        rd_mux = {28'h000_0000, zero_return_program};
			hrs_pkg::REG_STATUS:      rd_mux = status_word;
			hrs_pkg::REG_POSITION:    rd_mux = position;
			default:                  rd_mux = '0;
		endcase
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= reg_rd ? rd_mux : '0;
		end
	end

endmodule

// file: tb/hrs_chk.sv
// assertions on the home return sequencer top ports
`timescale 1ns/1ps
module hrs_chk (
	input wire logic        clk,
	input wire logic        rst_b,
	input wire logic        zero_return_command,
	input wire logic        op_mode_select_1,
	input wire logic [15:0] motion_speed,
	input wire logic        motion_dir,
	input wire logic        return_busy,
	input wire logic        home_complete_output,
	input wire logic        home_incomplete_warning
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	sequence s_go; !return_busy ##1 return_busy; endsequence
	property p_go; s_go |-> $past(zero_return_command) && $past(op_mode_select_1); endproperty
	a_go: assert property (p_go) else $error("busy without accepted start");
	property p_dir; $changed(motion_dir) |-> motion_speed == 16'h0; endproperty
	a_dir: assert property (p_dir) else $error("direction changed in motion");
	property p_idle; !return_busy |-> motion_speed == 16'h0; endproperty
	a_idle: assert property (p_idle) else $error("motion while idle");
	property p_step;
		$changed(motion_speed) |-> motion_speed - $past(motion_speed) inside {16'h1, 16'hffff};
	endproperty
	a_step: assert property (p_step) else $error("speed jumped");
	property p_done; $rose(home_complete_output) |-> !return_busy && !home_incomplete_warning; endproperty
	a_done: assert property (p_done) else $error("done while busy");
	property p_hold; home_complete_output |=> home_complete_output || return_busy; endproperty
	a_hold: assert property (p_hold) else $error("done dropped");
	property p_warn; home_incomplete_warning |=> home_incomplete_warning || return_busy; endproperty
	a_warn: assert property (p_warn) else $error("warning dropped");
	property p_clear; s_go |-> ##[0:1] !home_complete_output && !home_incomplete_warning; endproperty
	a_clear: assert property (p_clear) else $error("flags kept at start");
endmodule
bind hrs_top hrs_chk u_chk (.*);

// file: tb/hrs_far.sv
// behavioural axis: speed becomes encoder counts, with dog, z mark and stroke ends
`timescale 1ns/1ps
module hrs_far (
	input wire logic        clk,
	input wire logic [15:0] motion_speed,
	input wire logic        motion_dir,
	output logic            dog_input,
	output logic            z_phase,
	output logic            enc_step = 1'b0,
	output logic            enc_dir = 1'b0,
	output logic            fwd_end,
	output logic            rev_end
);
	logic dog_pol = 1'b1, dog_en = 1'b1;
	int   pos = 0, acc = 0;
	// one count for every 64 units of accumulated speed
	always @(posedge clk) begin
		acc = acc + int'(motion_speed);
		enc_step <= acc >= 64;
		enc_dir <= motion_dir;
		// non-blocking: the design samples dog, z and stroke ends of the old position on this edge
		pos <= acc < 64 ? pos : motion_dir ? pos - 1 : pos + 1;
		acc = acc % 64;
	end
	assign dog_input = (dog_en && pos >= 210 && pos <= 400) ? dog_pol : !dog_pol;
	assign z_phase = pos % 100 == 0;
	assign fwd_end = pos >= 600;
	assign rev_end = pos <= -100;
endmodule

// file: tb/hrs_top_test.sv
// bench: settings port, refused start and a table of home return runs
`timescale 1ns/1ps
module hrs_top_test;
	logic        clk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
	logic        zero_return_command = 1'b0, op_mode_select_1 = 1'b0;
	logic [3:0]  reg_addr = 4'h0, program_select = 4'h0;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic [15:0] motion_speed;
	logic        dog_input, z_phase, enc_step, enc_dir, fwd_end, rev_end, motion_dir, return_busy, done, warn;
	int          n_mismatch = 0, checks = 0;
	logic [31:0] cfg [6] = '{32'h8, 32'h2, 32'h5, 32'h1234, 32'h14, 32'h3};
	logic [3:0]  r_type [7] = '{4'h9, 4'h8, 4'ha, 4'h9, 4'h9, 4'h9, 4'h9};
	int          r_start [7] = '{0, 0, 110, 250, 500, 0, 0};
	int          r_home [7] = '{235, 195, 205, 235, 235, 235, 0};
	hrs_top dut (.clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .op_mode_select_1,
		.program_select, .zero_return_command, .dog_input, .forward_stroke_end_input(fwd_end),
		.reverse_stroke_end_input(rev_end), .z_phase, .enc_step, .enc_dir, .motion_speed, .motion_dir,
		.return_busy, .home_complete_output(done), .home_incomplete_warning(warn));
	hrs_far far (.clk, .motion_speed, .motion_dir, .dog_input, .z_phase, .enc_step, .enc_dir, .fwd_end, .rev_end);
	initial forever #5 clk = ~clk;
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		checks++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value at %0t: seen %h expected %h", $time, s, e);
		end
	endtask
	task automatic acc(input logic w, input logic [3:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= w;
		reg_rd <= !w;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		@(negedge clk);
		if (!w)
			chk(reg_rdata, d);
	endtask
	task automatic run;
		@(posedge clk);
		zero_return_command <= 1'b1;
		@(posedge clk);
		zero_return_command <= 1'b0;
		@(negedge clk);
		for (int t = 0; t < 20000 && return_busy !== 1'b0; t++)
			@(negedge clk);
		if (return_busy !== 1'b0)
			n_mismatch++;
	endtask
	task automatic summarize;
		$display("checks %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	initial begin
		#900us;
		n_mismatch++;
		summarize();
	end
	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		acc(0, 4'h0, 32'h8);
		acc(0, 4'hc, 32'h0);
		run();
		chk(return_busy, 1'b0);
		acc(0, 4'ha, 32'h0);
		@(posedge clk);
		op_mode_select_1 <= 1'b1;
		program_select <= 4'h3;
		run();
		acc(0, 4'ha, 32'h0);
		$display("test settings and refused start finished");
		for (int k = 0; k < 6; k++)
			acc(1, k < 5 ? 4'(k + 2) : 4'h9, cfg[k]);
		for (int i = 0; i < 7; i++) begin
			acc(1, 4'h0, {28'h0, r_type[i]});
			acc(1, 4'h1, {31'h0, i != 5});
			far.pos = r_start[i];
			far.dog_pol = i != 5;
			far.dog_en = i != 6;
			run();
			chk({30'h0, done, warn}, i == 6 ? 32'h1 : 32'h2);
			chk({15'h0, motion_dir, motion_speed}, {15'h0, i == 1 || i == 6, 16'h0});
			acc(0, 4'ha, i == 6 ? 32'h4 : 32'h2);
			if (i != 6)
				acc(0, 4'hb, 32'h1234 + far.pos - r_home[i]);
			$display("test run %0d finished", i);
		end
		summarize();
	end
endmodule
